// File: canopen_emergency_reporter.sv
// emergency telegram builder with register port and interrupt
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "emcy_params.svh"
module canopen_emergency_reporter (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // fault levels from detection logic, module details and node address
    input  wire logic [7:0]      comm_fault,
    input  wire logic [7:0]      device_fault_field,
    input  wire logic [7:0]      module_position,
    input  wire logic [7:0]      module_diag,
    input  wire logic [1:0]      module_channel,
    input  wire logic [6:0]      node_id,
    // telegram to the can controller
    output logic                 tx_valid,
    input  wire logic            tx_ready,
    output logic [10:0]          tx_id,
    output emcy_pkg::frame_t     tx_data,
    // register port
    input  wire logic [7:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [31:0]          reg_rdata,
    // interrupt
    output logic                 irq
);
    import emcy_pkg::*;

    // ==========================================================
    // state
    emcy_state_t  state_ff;
    logic         enable_ff;
    logic [10:0]  base_ff;
    logic [15:0]  prev_ff;
    logic [15:0]  raise_ff;
    logic [15:0]  clear_ff;
    logic [2:0]   stat_ff;
    logic [2:0]   irq_en_ff;
    logic [15:0]  cur;
    logic [15:0]  nxt_raise;
    logic [15:0]  nxt_clear;
    logic         go;
    logic         sel_raise;
    logic [3:0]   sel_idx;
    logic [15:0]  sel_mask;
    frame_t       nxt_data;
    byte_t        err_reg;
    logic         all_zero;
    logic [2:0]   ev;

    assign cur = {device_fault_field, comm_fault};

    // ==========================================================
    // fault edge tracking, set wins over consume
    always_comb begin
        nxt_raise = raise_ff;
        nxt_clear = clear_ff;
        if (go && sel_raise) begin
            nxt_raise = raise_ff & ~sel_mask;
        end
        if (go && !sel_raise) begin
            nxt_clear = clear_ff & ~sel_mask;
        end
        nxt_raise = nxt_raise | (cur & ~prev_ff);
        nxt_clear = nxt_clear | (~cur & prev_ff);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff  <= 16'h0000;
            raise_ff <= 16'h0000;
            clear_ff <= 16'h0000;
        end else begin
            prev_ff  <= cur;
            raise_ff <= nxt_raise;
            clear_ff <= nxt_clear;
        end
    end

    // ==========================================================
    // pick lowest pending source, new faults before cleared ones
    always_comb begin
        sel_raise = |raise_ff;
        sel_idx   = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (sel_raise ? raise_ff[i] : clear_ff[i]) begin
                sel_idx = 4'(i);
            end
        end
        sel_mask = 16'h0001 << sel_idx;
    end

    assign go = enable_ff && (state_ff == ST_IDLE)
              && (|raise_ff || |clear_ff);

    // ==========================================================
    // telegram assembly from the faults still present
    always_comb begin
        err_reg = 8'h00;
        err_reg[`EMCY_ERR_GENERIC] = |cur;
        err_reg[`EMCY_ERR_COMM]    = |comm_fault;
        err_reg[`EMCY_ERR_MANUF]   = |cur;
        nxt_data = 64'h0;
        // code, register, comm, device, trigger, details
        if (sel_raise) begin
            nxt_data[15:0] = sel_idx[3] ? `EMCY_CODE_HW
                                        : `EMCY_CODE_COMM;
        end else begin
            nxt_data[15:0] = 16'h0000;
        end
        nxt_data[23:16] = err_reg;
        nxt_data[31:24] = comm_fault;
        nxt_data[39:32] = device_fault_field;
        nxt_data[47:40] = trig_code(sel_idx);
        if (device_fault_field[`EMCY_DEV_MODULE]) begin
            nxt_data[55:48] = module_position;
            nxt_data[63:56] = {module_diag[7:2], module_channel};
        end
        all_zero = !sel_raise && (cur == 16'h0000);
        if (all_zero) begin
            nxt_data = 64'h0;
        end
    end

    // ==========================================================
    // telegram hand-off, held until the controller accepts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            tx_valid <= 1'b0;
            tx_id    <= 11'h000;
            tx_data  <= 64'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (go) begin
                        state_ff <= ST_SEND;
                        tx_valid <= 1'b1;
                        tx_id    <= base_ff + 11'(node_id);
                        tx_data  <= nxt_data;
                    end
                end
                ST_SEND: begin
                    if (tx_ready) begin
                        state_ff <= ST_IDLE;
                        tx_valid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff <= `EMCY_CTRL_RST;
            base_ff   <= `EMCY_COB_BASE;
            irq_en_ff <= 3'h0;
        end else if (reg_wr) begin
            if (reg_addr == `EMCY_REG_CTRL) begin
                enable_ff <= reg_wdata[0];
            end
            if (reg_addr == `EMCY_REG_BASE) begin
                base_ff <= reg_wdata[10:0];
            end
            if (reg_addr == `EMCY_REG_EN) begin
                irq_en_ff <= reg_wdata[2:0];
            end
        end
    end

    // status events of this cycle
    always_comb begin
        ev                   = 3'h0;
        ev[`EMCY_IRQ_SENT]   = tx_valid && tx_ready;
        ev[`EMCY_IRQ_RAISE]  = |(cur & ~prev_ff);
        ev[`EMCY_IRQ_ALLCLR] = go && all_zero;
    end

    // sticky events, set wins over write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == `EMCY_REG_CLR) begin
                stat_ff <= (stat_ff & ~reg_wdata[2:0]) | ev;
            end else begin
                stat_ff <= stat_ff | ev;
            end
        end
    end

    // level interrupt from enabled status bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_ff & irq_en_ff);
        end
    end

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `EMCY_REG_CTRL:   reg_rdata <= {31'h0, enable_ff};
                `EMCY_REG_BASE:   reg_rdata <= {21'h0, base_ff};
                `EMCY_REG_FAULTS: reg_rdata <= {16'h0, prev_ff};
                `EMCY_REG_STAT:   reg_rdata <= {29'h0, stat_ff};
                `EMCY_REG_EN:     reg_rdata <= {29'h0, irq_en_ff};
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_launch;
        go;
    endsequence
    sequence s_offer;
        tx_valid && !tx_ready;
    endsequence
    sequence s_module_launch;
        go && device_fault_field[`EMCY_DEV_MODULE];
    endsequence
    sequence s_clear_launch;
        go && !sel_raise && cur != 16'h0000;
    endsequence
    sequence s_final_launch;
        go && all_zero;
    endsequence
    sequence s_accept;
        tx_valid && tx_ready;
    endsequence

    chk_cob_id_sum: assert property (
        s_launch |=> tx_id == $past(base_ff) + 11'($past(node_id)))
        else $error("identifier not base plus node address");
    chk_warn_trigger: assert property (
        tx_valid && tx_data[47:40] == `EMCY_TRIG_WARN
        && tx_data[15:0] != 16'h0000 |-> tx_data[31])
        else $error("warning telegram lacks comm bit 7");
    chk_comm_code: assert property (
        tx_valid && tx_data[15:0] == `EMCY_CODE_COMM
        |-> tx_data[23:16] != 8'h00 && tx_data[7:0] == 8'h00)
        else $error("comm code or error register wrong");
    chk_err_reg: assert property (
        tx_valid |-> tx_data[20] == (tx_data[31:24] != 8'h00)
        && tx_data[23] == (tx_data[39:24] != 16'h0000)
        && tx_data[16] == tx_data[23])
        else $error("error register disagrees with fields");
    chk_module_code: assert property (
        tx_valid && tx_data[47:40] == `EMCY_TRIG_MODULE
        && tx_data[15:0] != 16'h0000
        |-> tx_data[15:0] == `EMCY_CODE_HW && tx_data[32])
        else $error("module telegram code or field wrong");
    chk_detail_bytes: assert property (
        s_module_launch |=> tx_data[55:48] == $past(module_position))
        else $error("first detail byte not module position");
    chk_chan_field: assert property (
        s_module_launch |=> tx_data[57:56] == $past(module_channel))
        else $error("channel field wrong");
    chk_clear_fields: assert property (
        s_clear_launch
        |=> tx_data[15:0] == 16'h0000
        && tx_data[39:24] == $past(cur))
        else $error("clear telegram fields wrong");
    chk_all_zero: assert property (
        s_final_launch |=> tx_valid && tx_data == 64'h0)
        else $error("final telegram not all zero");
    chk_hold_offer: assert property (
        s_offer |=> tx_valid && $stable(tx_data) && $stable(tx_id))
        else $error("telegram changed before acceptance");
    chk_warn_launch: assert property (
        s_launch and (sel_raise && sel_idx == 4'h7)
        |=> tx_data[47:40] == `EMCY_TRIG_WARN && tx_data[31])
        else $error("warning telegram trigger or bit wrong");
    chk_comm_kept: assert property (
        s_module_launch |=> tx_data[31:24] == $past(comm_fault))
        else $error("comm bits lost in module telegram");
    chk_diag_upper: assert property (
        s_module_launch
        |=> tx_data[63:58] == 6'($past(module_diag) >> 2))
        else $error("second detail byte not diagnostic code");
    chk_clear_code: assert property (
        s_clear_launch or s_final_launch |=> tx_data[15:0] == 16'h0000)
        else $error("clear telegram code not zero");
    chk_comm_field: assert property (
        s_launch and !all_zero |=> tx_data[31:24] == $past(comm_fault))
        else $error("comm field wrong");
    chk_dev_field: assert property (
        s_launch and !all_zero
        |=> tx_data[39:32] == $past(device_fault_field))
        else $error("device field wrong");
    chk_accept_drop: assert property (
        s_accept |=> !tx_valid)
        else $error("offer kept after acceptance");
endmodule : canopen_emergency_reporter
`default_nettype wire

// File: emcy_params.svh
// constants of the emergency telegram reporter
`ifndef EMCY_PARAMS_SVH
`define EMCY_PARAMS_SVH
// ==========================================================
// telegram contents
`define EMCY_COB_BASE     11'h080
`define EMCY_CODE_COMM    16'h8100
`define EMCY_CODE_HW      16'h5000
`define EMCY_ERR_GENERIC  0
`define EMCY_ERR_COMM     4
`define EMCY_ERR_MANUF    7
`define EMCY_DEV_MODULE   0
`define EMCY_TRIG_WARN    8'h01
`define EMCY_TRIG_MODULE  8'h10
`define EMCY_TRIG_BUSOFF  8'h40
`define EMCY_TRIG_OTHER   8'hF0
// ==========================================================
// register offsets and reset values
`define EMCY_REG_CTRL     8'h00
`define EMCY_REG_BASE     8'h04
`define EMCY_REG_FAULTS   8'h08
`define EMCY_REG_STAT     8'h0C
`define EMCY_REG_CLR      8'h10
`define EMCY_REG_EN       8'h14
`define EMCY_CTRL_RST     1'h1
`define EMCY_IRQ_SENT     0
`define EMCY_IRQ_RAISE    1
`define EMCY_IRQ_ALLCLR   2
`endif

// File: emcy_pkg.sv
// types of the emergency telegram reporter
`default_nettype none
`include "emcy_params.svh"
package emcy_pkg;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } emcy_state_t;
    typedef logic [7:0]  byte_t;
    typedef logic [63:0] frame_t;

    // trigger byte for a fault source: 0-7 comm bits, 8-15 device bits
    function automatic byte_t trig_code(input logic [3:0] src);
        unique case (src)
            4'h7: trig_code = `EMCY_TRIG_WARN;
            4'h6: trig_code = `EMCY_TRIG_BUSOFF;
            4'h8: trig_code = `EMCY_TRIG_MODULE;
            default: trig_code = byte_t'({4'hF, src});
        endcase
    endfunction : trig_code
endpackage : emcy_pkg
`default_nettype wire

// File: emcy_can_sink.sv
// behavioural can controller that takes emergency telegrams
`timescale 1ns/10ps
`default_nettype none
module emcy_can_sink (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // telegram offer
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire logic [10:0] tx_id,
    input  wire logic [63:0] tx_data,
    // stall length and captured telegram
    input  wire logic [3:0]  stall,
    output logic [10:0]      got_id,
    output logic [63:0]      got_data,
    output logic [7:0]       got_count
);
    logic [3:0] wait_ff;
    // ==========================================================
    // accept after the chosen number of stall cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ready  <= 1'b0;
            wait_ff   <= 4'h0;
            got_id    <= 11'h000;
            got_data  <= 64'h0;
            got_count <= 8'h00;
        end else if (tx_valid && tx_ready) begin
            tx_ready  <= 1'b0;
            wait_ff   <= 4'h0;
            got_id    <= tx_id;
            got_data  <= tx_data;
            got_count <= got_count + 8'h01;
        end else if (tx_valid) begin
            if (wait_ff >= stall) tx_ready <= 1'b1;
            else wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule : emcy_can_sink
`default_nettype wire

// File: canopen_emergency_reporter_tb.sv
// self-checking bench of the emergency telegram reporter
`timescale 1ns/10ps
`default_nettype none
module canopen_emergency_reporter_tb;
    logic clk, rst_n, tx_valid, tx_ready, reg_wr, reg_rd, irq;
    logic [7:0]  comm_fault, device_fault_field, module_position;
    logic [7:0]  module_diag, reg_addr, got_count, n0, tb, bb;
    logic [1:0]  module_channel;
    logic [6:0]  node_id;
    logic [10:0] tx_id, got_id;
    logic [63:0] tx_data, got_data;
    logic [31:0] reg_wdata, reg_rdata;
    logic [3:0]  stall;
    int n_fail = 0, n_compared = 0, cyc = 0;
    canopen_emergency_reporter dut_u (.clk(clk), .rst_n(rst_n),
        .comm_fault(comm_fault), .device_fault_field(device_fault_field),
        .module_position(module_position), .module_diag(module_diag),
        .module_channel(module_channel), .node_id(node_id),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
        .tx_data(tx_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq));
    emcy_can_sink sink_u (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_id(tx_id), .tx_data(tx_data),
        .stall(stall), .got_id(got_id), .got_data(got_data),
        .got_count(got_count));
    // ==========================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(64'(reg_rdata), 64'(exp));
    endtask : rd
    task automatic setf(input logic [7:0] c, input logic [7:0] d);
        @(posedge clk);
        comm_fault <= c; device_fault_field <= d;
    endtask : setf
    task automatic expect_tx(input logic [10:0] id, input logic [63:0] d);
        int k;
        k = 0;
        while (got_count === n0 && k < 60) begin
            @(posedge clk); #1; k++;
        end
        check(64'(k < 60), 64'h1);
        check(64'(got_id), 64'(id));
        check(got_data, d);
        n0 = got_count;
    endtask : expect_tx
    // ==========================================================
    // scenarios
    task automatic t_sample;
        stall = 4'h3;
        setf(8'h80, 8'h00);
        expect_tx(11'h085, 64'h0000_0100_8091_8100);
        setf(8'h80, 8'h01);
        expect_tx(11'h085, 64'h810A_1001_8091_5000);
        setf(8'h00, 8'h01);
        expect_tx(11'h085, 64'h810A_0101_0081_0000);
        setf(8'h00, 8'h00);
        expect_tx(11'h085, 64'h0);
        $display("test sample done");
    endtask : t_sample
    task automatic t_comm_bits;
        stall = 4'h0;
        for (int i = 0; i < 8; i++) begin
            bb = 8'h01 << i;
            tb = (i == 7) ? 8'h01 : (i == 6) ? 8'h40 : 8'hF0 | 8'(i);
            setf(bb, 8'h00);
            expect_tx(11'h085, {16'h0, tb, 8'h00, bb, 24'h918100});
            setf(8'h00, 8'h00);
            expect_tx(11'h085, 64'h0);
        end
        $display("test comm bits done");
    endtask : t_comm_bits
    task automatic t_dev_bits;
        int s[4] = '{1, 2, 4, 7};
        for (int i = 0; i < 4; i++) begin
            bb = 8'h01 << s[i];
            setf(8'h00, bb);
            expect_tx(11'h085,
                {16'h0, 8'hF8 | 8'(s[i]), bb, 32'h0081_5000});
            setf(8'h00, 8'h00);
            expect_tx(11'h085, 64'h0);
        end
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            module_channel <= 2'(c);
            setf(8'h00, 8'h01);
            expect_tx(11'h085,
                {8'h80 | 8'(c), 56'h0A_1001_0081_5000});
            setf(8'h00, 8'h00);
            expect_tx(11'h085, 64'h0);
        end
        $display("test device bits done");
    endtask : t_dev_bits
    task automatic t_regs_irq;
        rd(8'h04, 32'h080);
        rd(8'h3C, 32'h0);
        wr(8'h10, 32'h7);
        wr(8'h14, 32'h2);
        setf(8'h01, 8'h00);
        expect_tx(11'h085, 64'h0000_F000_0191_8100);
        repeat (2) @(posedge clk);
        #1 check(64'(irq), 64'h1);
        rd(8'h0C, 32'h3);
        wr(8'h10, 32'h2);
        repeat (3) @(posedge clk);
        #1 check(64'(irq), 64'h0);
        setf(8'h00, 8'h00);
        expect_tx(11'h085, 64'h0);
        wr(8'h00, 32'h0);
        setf(8'h04, 8'h00);
        repeat (8) @(posedge clk);
        #1 check(64'(tx_valid), 64'h0);
        rd(8'h08, 32'h0004);
        wr(8'h04, 32'h100);
        wr(8'h00, 32'h1);
        expect_tx(11'h105, 64'h0000_F200_0491_8100);
        setf(8'h00, 8'h00);
        expect_tx(11'h105, 64'h0);
        $display("test registers and interrupt done");
    endtask : t_regs_irq
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0; comm_fault = 8'h00; device_fault_field = 8'h00;
        module_position = 8'h0A; module_diag = 8'h80;
        module_channel = 2'b01; node_id = 7'h05; stall = 4'h0;
        reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0;
        reg_rd = 1'b0; n0 = 8'h00;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_sample();
        t_comm_bits();
        t_dev_bits();
        t_regs_irq();
        end_of_test();
    end
endmodule : canopen_emergency_reporter_tb
`default_nettype wire
